// *** src/css_pkg.sv ***
// Contract
// - each command source is a 2-bit code: 0 pin, 1 serial, 2 AND, 3 OR.
// - brake pin-only uses pins alone, serial-only uses serial bit; low brakes.
// - brake pins and control word bit 03 active low; AND both low, OR either.
// - start follows pin, serial, both high, or either high; otherwise stop.
// - reverse follows pin; serial-only and AND need both; OR needs either.
// - reversing source resets to pin-only, code 0.
// - pin-only selection ignores bus bits; number is pin value plus one.
// - one merge rule drives setup and preset numbers, each with own source.
// - setup and preset selection sources reset to OR, code 3.
// - serial-only obeys serial bit alone, except reverse, which also needs the pin; AND also needs the pin active.
package css_pkg;

  // ----------------------------------------------------------------
  // source codes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CSS_SRC_PIN,
    CSS_SRC_SERIAL,
    CSS_SRC_AND,
    CSS_SRC_OR
  } css_mode_type;

  // ----------------------------------------------------------------
  // commands and mode field layout
  // ----------------------------------------------------------------
  localparam int          CSS_NUM_CMD    = 5;
  localparam int          CSS_CMD_BRAKE  = 0;
  localparam int          CSS_CMD_START  = 1;
  localparam int          CSS_CMD_REV    = 2;
  localparam int          CSS_CMD_SETUP  = 3;
  localparam int          CSS_CMD_PRESET = 4;
  localparam int          CSS_MODE_W     = 2;
  localparam int          CSS_MODE_REG_W = CSS_NUM_CMD * CSS_MODE_W;
  // brake OR, start OR, reverse pin, setup OR, preset OR
  localparam logic [9:0]  CSS_MODE_RESET = 10'h3cf;

  // ----------------------------------------------------------------
  // apb map
  // ----------------------------------------------------------------
  localparam int          CSS_ADDR_W     = 8;
  localparam logic [7:0]  CSS_OFF_MODE   = 8'h00;
  localparam logic [7:0]  CSS_OFF_CWORD  = 8'h04;
  localparam logic [7:0]  CSS_OFF_STATUS = 8'h08;

  // ----------------------------------------------------------------
  // control word bits
  // ----------------------------------------------------------------
  localparam int          CSS_CW_W       = 16;
  localparam int          CSS_CW_BRAKE_N = 3;
  localparam int          CSS_CW_START   = 6;
  localparam int          CSS_CW_SEL_LSB = 13;
  localparam int          CSS_CW_REVERSE = 15;
  localparam logic [15:0] CSS_CW_RESET   = 16'h0008;

  // ----------------------------------------------------------------
  // status word layout
  // ----------------------------------------------------------------
  localparam int          CSS_ST_CMD_LSB = 0;
  localparam int          CSS_ST_NO_LSB  = 4;
  localparam int          CSS_ST_PIN_LSB = 16;
  localparam logic [2:0]  CSS_NO_OFFSET  = 3'h1;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       brake_a_n;
    logic       brake_b_n;
    logic       start_input_pin;
    logic       reverse_input_pin;
    logic [1:0] sel;
  } css_pins_type;

  typedef struct packed {
    logic       dc_brake;
    logic       start;
    logic       reverse;
    logic [2:0] setup_no;
    logic [2:0] preset_no;
  } css_cmd_type;

  function automatic css_mode_type css_mode_of(input logic [9:0] modes, input int idx);
    css_mode_of = css_mode_type'(modes[idx*CSS_MODE_W +: CSS_MODE_W]);
  endfunction

endpackage

// *** src/css_merge.sv ***
module css_merge (
  input  wire css_pkg::css_mode_type mode_in,
  input  wire logic                  serial_needs_pin_in,
  input  wire logic [1:0]            pin_in,
  input  wire logic [1:0]            ser_in,
  output logic      [1:0]            merged_out
);

  // ----------------------------------------------------------------
  // per-bit source merge, inputs already active high
  // ----------------------------------------------------------------
  always_comb begin
    case (mode_in)
      css_pkg::CSS_SRC_PIN: begin
        merged_out = pin_in;
      end
      css_pkg::CSS_SRC_SERIAL: begin
        // reversing still wants the pin in serial mode
        merged_out = serial_needs_pin_in ? (pin_in & ser_in) : ser_in;
      end
      css_pkg::CSS_SRC_AND: begin
        merged_out = pin_in & ser_in;
      end
      css_pkg::CSS_SRC_OR: begin
        merged_out = pin_in | ser_in;
      end
      default: begin
        merged_out = pin_in;
      end
    endcase
  end

endmodule

// *** src/css_top.sv ***
// Chosen here: the placing of the registers and the APB interface to the registers.
module css_top (
  input  wire logic                     core_clk_in,
  input  wire logic                     srst_in,
  // apb slave
  input  wire logic                     psel_in,
  input  wire logic                     penable_in,
  input  wire logic                     pwrite_in,
  input  wire logic [css_pkg::CSS_ADDR_W-1:0] paddr_in,
  input  wire logic [31:0]              pwdata_in,
  input  wire logic [3:0]               pstrb_in,
  output logic      [31:0]              prdata_out,
  output logic                          pready_out,
  output logic                          pslverr_out,
  // control pins
  input  wire css_pkg::css_pins_type    pins_in,
  // merged commands
  output css_pkg::css_cmd_type          cmd_out
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  css_pkg::css_pins_type                 pin_meta;
  css_pkg::css_pins_type                 pin_sync;
  logic [css_pkg::CSS_MODE_REG_W-1:0]    modes;
  logic [css_pkg::CSS_MODE_REG_W-1:0]    next_modes;
  logic [css_pkg::CSS_CW_W-1:0]          cword;
  logic [css_pkg::CSS_CW_W-1:0]          next_cword;
  logic [31:0]                           rdata;
  logic [31:0]                           next_rdata;
  logic                                  slverr;
  logic                                  next_slverr;
  css_pkg::css_cmd_type                  cmd;
  css_pkg::css_cmd_type                  next_cmd;

  logic [1:0]                            pin_vec [css_pkg::CSS_NUM_CMD];
  logic [1:0]                            ser_vec [css_pkg::CSS_NUM_CMD];
  logic [1:0]                            merged  [css_pkg::CSS_NUM_CMD];

  logic                                  setup_phase;
  logic                                  access_wr;
  logic                                  addr_hit;

  // ----------------------------------------------------------------
  // pin synchroniser
  // ----------------------------------------------------------------
  // pins are asynchronous; only the second stage feeds logic
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      pin_meta <= '0;
      pin_sync <= '0;
    end else begin
      pin_meta <= pins_in;
      pin_sync <= pin_meta;
    end
  end

  // ----------------------------------------------------------------
  // source vectors, brake turned active high
  // ----------------------------------------------------------------
  always_comb begin
    // either brake pin low requests braking
    pin_vec[css_pkg::CSS_CMD_BRAKE]  = {1'b0, ~(pin_sync.brake_a_n & pin_sync.brake_b_n)};
    ser_vec[css_pkg::CSS_CMD_BRAKE]  = {1'b0, ~cword[css_pkg::CSS_CW_BRAKE_N]};
    pin_vec[css_pkg::CSS_CMD_START]  = {1'b0, pin_sync.start_input_pin};
    ser_vec[css_pkg::CSS_CMD_START]  = {1'b0, cword[css_pkg::CSS_CW_START]};
    pin_vec[css_pkg::CSS_CMD_REV]    = {1'b0, pin_sync.reverse_input_pin};
    ser_vec[css_pkg::CSS_CMD_REV]    = {1'b0, cword[css_pkg::CSS_CW_REVERSE]};
    pin_vec[css_pkg::CSS_CMD_SETUP]  = pin_sync.sel;
    ser_vec[css_pkg::CSS_CMD_SETUP]  = cword[css_pkg::CSS_CW_SEL_LSB +: 2];
    pin_vec[css_pkg::CSS_CMD_PRESET] = pin_sync.sel;
    ser_vec[css_pkg::CSS_CMD_PRESET] = cword[css_pkg::CSS_CW_SEL_LSB +: 2];
  end

  // ----------------------------------------------------------------
  // one merge per command
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < css_pkg::CSS_NUM_CMD; gi++) begin : g_merge
      css_merge u_merge (
        .mode_in             (css_pkg::css_mode_of(modes, gi)),
        .serial_needs_pin_in (gi == css_pkg::CSS_CMD_REV),
        .pin_in              (pin_vec[gi]),
        .ser_in              (ser_vec[gi]),
        .merged_out          (merged[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // registered commands
  // ----------------------------------------------------------------
  always_comb begin
    next_cmd.dc_brake  = merged[css_pkg::CSS_CMD_BRAKE][0];
    next_cmd.start     = merged[css_pkg::CSS_CMD_START][0];
    next_cmd.reverse   = merged[css_pkg::CSS_CMD_REV][0];
    next_cmd.setup_no  = {1'b0, merged[css_pkg::CSS_CMD_SETUP]} + css_pkg::CSS_NO_OFFSET;
    next_cmd.preset_no = {1'b0, merged[css_pkg::CSS_CMD_PRESET]} + css_pkg::CSS_NO_OFFSET;
  end

  // one cycle of latency buys glitch-free outputs to the drive
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      cmd.dc_brake  <= 1'b0;
      cmd.start     <= 1'b0;
      cmd.reverse   <= 1'b0;
      cmd.setup_no  <= css_pkg::CSS_NO_OFFSET;
      cmd.preset_no <= css_pkg::CSS_NO_OFFSET;
    end else begin
      cmd <= next_cmd;
    end
  end

  assign cmd_out = cmd;

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  assign setup_phase = psel_in & ~penable_in;
  assign access_wr   = psel_in & penable_in & pwrite_in;
  assign addr_hit    = (paddr_in == css_pkg::CSS_OFF_MODE) |
                       (paddr_in == css_pkg::CSS_OFF_CWORD) |
                       (paddr_in == css_pkg::CSS_OFF_STATUS);

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  always_comb begin
    next_modes = modes;
    next_cword = cword;
    if (access_wr && paddr_in == css_pkg::CSS_OFF_MODE) begin
      if (pstrb_in[0]) begin
        next_modes[7:0] = pwdata_in[7:0];
      end
      if (pstrb_in[1]) begin
        next_modes[css_pkg::CSS_MODE_REG_W-1:8] = pwdata_in[css_pkg::CSS_MODE_REG_W-1:8];
      end
    end
    if (access_wr && paddr_in == css_pkg::CSS_OFF_CWORD) begin
      if (pstrb_in[0]) begin
        next_cword[7:0] = pwdata_in[7:0];
      end
      if (pstrb_in[1]) begin
        next_cword[15:8] = pwdata_in[15:8];
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      modes <= css_pkg::CSS_MODE_RESET;
      cword <= css_pkg::CSS_CW_RESET;
    end else begin
      modes <= next_modes;
      cword <= next_cword;
    end
  end

  // ----------------------------------------------------------------
  // read path, captured in the setup cycle
  // ----------------------------------------------------------------
  // status is snapshotted one cycle before the answer, which is harmless
  always_comb begin
    next_rdata  = rdata;
    next_slverr = slverr;
    if (setup_phase) begin
      next_rdata  = '0;
      next_slverr = ~addr_hit;
      case (paddr_in)
        css_pkg::CSS_OFF_MODE: begin
          next_rdata[css_pkg::CSS_MODE_REG_W-1:0] = modes;
        end
        css_pkg::CSS_OFF_CWORD: begin
          next_rdata[css_pkg::CSS_CW_W-1:0] = cword;
        end
        css_pkg::CSS_OFF_STATUS: begin
          next_rdata[css_pkg::CSS_ST_CMD_LSB +: 3] = {cmd.reverse, cmd.start, cmd.dc_brake};
          next_rdata[css_pkg::CSS_ST_NO_LSB +: 6]  = {cmd.preset_no, cmd.setup_no};
          next_rdata[css_pkg::CSS_ST_PIN_LSB +: 6] = pin_sync;
        end
        default: begin
          next_rdata = '0;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      rdata  <= '0;
      slverr <= 1'b0;
    end else begin
      rdata  <= next_rdata;
      slverr <= next_slverr;
    end
  end

  // every access completes in its first access cycle
  assign pready_out  = 1'b1;
  assign prdata_out  = rdata;
  assign pslverr_out = slverr & psel_in & penable_in;

endmodule

// *** verif/css_top_chk.sv ***
module css_top_chk (
  input wire logic                             core_clk_in,
  input wire logic                             srst_in,
  input wire logic                             psel_in,
  input wire logic                             penable_in,
  input wire logic                             pwrite_in,
  input wire logic [css_pkg::CSS_ADDR_W-1:0]   paddr_in,
  input wire logic [31:0]                      pwdata_in,
  input wire logic [3:0]                       pstrb_in,
  input wire logic [31:0]                      prdata_out,
  input wire logic                             pready_out,
  input wire logic                             pslverr_out,
  input wire css_pkg::css_pins_type            pins_in,
  input wire css_pkg::css_cmd_type             cmd_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (srst_in);
  logic acc;
  logic mapped;
  assign acc = psel_in && penable_in;
  assign mapped = paddr_in inside {8'h00, 8'h04, 8'h08};
  sequence s_status_setup;
    psel_in && !penable_in && !pwrite_in && paddr_in == 8'h08;
  endsequence
  sequence s_access;
    psel_in && penable_in;
  endsequence
  property p_status_snap;
    s_status_setup ##1 s_access |-> prdata_out[9:0] == {$past(cmd_out.preset_no), $past(cmd_out.setup_no),
      1'b0, $past(cmd_out.reverse), $past(cmd_out.start), $past(cmd_out.dc_brake)};
  endproperty
  a_status_snap: assert property (p_status_snap) else $error("status read differs from commands");
  property p_cmd_hold;
    (!psel_in && $stable(pins_in))[*5] |=> $stable(cmd_out);
  endproperty
  a_cmd_hold: assert property (p_cmd_hold) else $error("commands moved with quiet sources");
  property p_rst_cmd;
    $fell(srst_in) |-> cmd_out == {3'b000, 3'h1, 3'h1};
  endproperty
  a_rst_cmd: assert property (p_rst_cmd) else $error("commands not idle after reset");
  property p_setup_rng;
    cmd_out.setup_no inside {[3'h1:3'h4]};
  endproperty
  a_setup_rng: assert property (p_setup_rng) else $error("setup number out of range");
  property p_preset_rng;
    cmd_out.preset_no inside {[3'h1:3'h4]};
  endproperty
  a_preset_rng: assert property (p_preset_rng) else $error("preset number out of range");
  property p_modes_hi;
    acc && !pwrite_in && paddr_in == 8'h00 |-> prdata_out[31:10] == 22'h0;
  endproperty
  a_modes_hi: assert property (p_modes_hi) else $error("mode word upper bits set");
  property p_rdy;
    pready_out;
  endproperty
  a_rdy: assert property (p_rdy) else $error("ready low");
  property p_err;
    acc && !mapped |-> pslverr_out && prdata_out == 32'h0;
  endproperty
  a_err: assert property (p_err) else $error("unmapped access not refused");
  property p_noerr;
    !(acc && !mapped) |-> !pslverr_out;
  endproperty
  a_noerr: assert property (p_noerr) else $error("error flag without cause");
endmodule
bind css_top css_top_chk u_chk (.core_clk_in, .srst_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
  .pwdata_in, .pstrb_in, .prdata_out, .pready_out, .pslverr_out, .pins_in, .cmd_out);

// *** verif/css_pin_model.sv ***
module css_pin_model (
  input  wire logic                  core_clk_in,
  input  wire css_pkg::css_pins_type level_in,
  output css_pkg::css_pins_type      pins_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // pins settle just after an edge, unrelated to any bus transfer
  initial pins_out = 6'h30;
  always @(posedge core_clk_in) pins_out <= level_in;
endmodule

// *** verif/css_top_tb.sv ***
module css_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                  core_clk_in = 1'b0;
  logic                  srst_in = 1'b1;
  logic                  psel_in = 1'b0;
  logic                  penable_in = 1'b0;
  logic                  pwrite_in = 1'b0;
  logic [7:0]            paddr_in = 8'h00;
  logic [31:0]           pwdata_in = 32'h0;
  logic [3:0]            pstrb_in = 4'hf;
  logic [31:0]           prdata_out;
  logic                  pready_out;
  logic                  pslverr_out;
  css_pkg::css_pins_type level = 6'h30;
  css_pkg::css_pins_type pins_in;
  css_pkg::css_cmd_type  cmd_out;
  int                    fails = 0;
  int                    samples_checked = 0;
  css_top dut_u (.core_clk_in(core_clk_in), .srst_in(srst_in), .psel_in(psel_in), .penable_in(penable_in),
    .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .pstrb_in(pstrb_in),
    .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out), .pins_in(pins_in),
    .cmd_out(cmd_out));
  css_pin_model pin_u (.core_clk_in(core_clk_in), .level_in(level), .pins_out(pins_in));
  initial forever #12.5 core_clk_in = ~core_clk_in;
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd,
                     output logic err);
    @(posedge core_clk_in);
    psel_in <= 1'b1;
    pwrite_in <= wr;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge core_clk_in);
    penable_in <= 1'b1;
    // the wait for the answer ends once pready_out is high; only a stall is left to the watchdog
    do begin
      @(posedge core_clk_in);
    end while (pready_out !== 1'b1);
    rd = prdata_out;
    err = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask
  task automatic stop_test;
    $display("mismatches %0d comparisons %0d", fails, samples_checked);
    if (fails == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  function automatic logic [1:0] mrg(input int m, input logic [1:0] p, input logic [1:0] s, input logic rv);
    case (m)
      0: mrg = p;
      1: mrg = rv ? p & s : s;
      2: mrg = p & s;
      default: mrg = p | s;
    endcase
  endfunction
  initial begin
    repeat (5000) @(posedge core_clk_in);
    fails++;
    stop_test();
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] rd;
    logic        err, a, b;
    logic [1:0]  sa, sb, br, st, rv;
    logic [2:0]  su, pr;
    int          m2;
    repeat (8) @(posedge core_clk_in);
    srst_in <= 1'b0;
    apb(1'b0, 8'h00, 32'h0, rd, err);
    check(rd, 32'h3cf);
    apb(1'b0, 8'h04, 32'h0, rd, err);
    check(rd, 32'h8);
    apb(1'b0, 8'h0c, 32'h0, rd, err);
    check(rd, 32'h0);
    check(err, 32'h1);
    for (int m = 0; m < 4; m++) begin
      m2 = (m + 1) % 4;
      apb(1'b1, 8'h00, {22'h0, m2[1:0], m[1:0], m[1:0], m[1:0], m[1:0]}, rd, err);
      for (int i = 0; i < 16; i++) begin
        sa = i[3:2];
        sb = i[1:0];
        a = sa[0];
        b = sb[0];
        // each brake pin goes low on its own, the pair still requests !a
        level <= {a | sa[1], a | ~sa[1], a, a, sa};
        apb(1'b1, 8'h04, {16'h0, b, sb, 6'h0, b, 2'h0, b, 3'h0}, rd, err);
        repeat (6) @(posedge core_clk_in);
        br = mrg(m, {1'b0, !a}, {1'b0, !b}, 1'b0);
        st = mrg(m, {1'b0, a}, {1'b0, b}, 1'b0);
        rv = mrg(m, {1'b0, a}, {1'b0, b}, 1'b1);
        su = {1'b0, mrg(m, sa, sb, 1'b0)} + 3'h1;
        pr = {1'b0, mrg(m2, sa, sb, 1'b0)} + 3'h1;
        check(cmd_out, {br[0], st[0], rv[0], su, pr});
        apb(1'b0, 8'h08, 32'h0, rd, err);
        check(rd, {10'h0, level, 6'h0, pr, su, 1'b0, rv[0], st[0], br[0]});
        check(err, 32'h0);
      end
    end
    // upper lane only: mode bits 9:8 change, low byte kept
    pstrb_in <= 4'h2;
    apb(1'b1, 8'h00, 32'h2aa, rd, err);
    pstrb_in <= 4'hf;
    apb(1'b0, 8'h00, 32'h0, rd, err);
    check(rd, 32'h2ff);
    apb(1'b1, 8'h0c, 32'h3ff, rd, err);
    check(err, 32'h1);
    apb(1'b0, 8'h00, 32'h0, rd, err);
    check(rd, 32'h2ff);
    srst_in <= 1'b1;
    repeat (2) @(posedge core_clk_in);
    srst_in <= 1'b0;
    apb(1'b0, 8'h00, 32'h0, rd, err);
    check(rd, 32'h3cf);
    stop_test();
  end
endmodule
